// [flash_output_mux_selector.sv]
// Output source selector of a partitioned flash command interface.
// Assumes write requests and chip state come from logic on the same clock.
// Functional notes
// - command-setup and busy-factory states: any command selects status
// - FFH selects array; setup codes, 70H select status
// - D0H, B0H, 50H keep the current source
// - 60H and C0H select status
// - 01H, 2FH, 03H, illegal, completion keep; address match array
// - array read of busy partition flagged invalid
// - suspended program: erase setup then D0H ignored
// - clear status only when no operation runs
// - factory data accepted only while status bit0 zero
// - source decision depends on chip state, command and block match only
// - each partition keeps its last selected source
// - lock and configuration confirms act, then ready
// - first-cycle block address latched, later compared
// - codes outside command set are illegal
`timescale 1ns/1ps
`include "flash_mux_consts.svh"
module flash_output_mux_selector #(
  parameter int PARTS = 4
) (
  input  wire logic                         clk_i,
  input  wire logic                         reset_n_i,
  input  wire logic                         wr_i,
  input  wire flash_mux_pkg::wr_req_type    wr_req_i,
  input  wire flash_mux_pkg::chip_class_type chip_class_i,
  input  wire logic                         wsm_running_i,
  input  wire logic                         pgm_suspended_i,
  input  wire logic                         status_bit0_i,
  input  wire logic [PARTS-1:0]             part_busy_i,
  output flash_mux_pkg::mux_src_type [PARTS-1:0] mux_sel_o,
  output logic [PARTS-1:0]                  array_invalid_o,
  output logic [`BLK_W-1:0]                 first_cycle_block_address_o,
  output logic                              clear_status_o,
  output logic                              bulk_factory_program_accept_o,
  output logic                              confirm_ready_o,
  output logic                              erase_confirm_o,
  output logic                              second_ignored_o,
  output logic                              illegal_cmd_o
);
  import flash_mux_pkg::*;

  // ************************************************************
  // Decode
  // ************************************************************
  function automatic logic is_legal(input logic [`CMD_W-1:0] c);
    case (c)
      `CMD_READ_ARRAY, `CMD_WORD_PGM_A, `CMD_WORD_PGM_B, `CMD_BUF_PGM, `CMD_ERASE, `CMD_BULK_FACTORY_PROGRAM,
      `CMD_CONFIRM, `CMD_SUSPEND, `CMD_READ_STATUS, `CMD_CLR_STATUS, `CMD_ID_QUERY_A,
      `CMD_ID_QUERY_B, `CMD_LOCK_SETUP, `CMD_OTP_SETUP, `CMD_LOCK_BLOCK, `CMD_LOCK_DOWN,
      `CMD_CFG_CONFIRM: is_legal = 1'b1;
      default: is_legal = 1'b0;
    endcase
  endfunction

  function automatic logic is_setup(input logic [`CMD_W-1:0] c);
    is_setup = (c == `CMD_WORD_PGM_A) || (c == `CMD_WORD_PGM_B) || (c == `CMD_BUF_PGM) ||
               (c == `CMD_ERASE) || (c == `CMD_BULK_FACTORY_PROGRAM) || (c == `CMD_LOCK_SETUP) || (c == `CMD_OTP_SETUP);
  endfunction

  // The current source is deliberately not an argument.
  function automatic src_decision_type decide(input chip_class_type cls, input logic [`CMD_W-1:0] c,
                                              input logic match);
    decide = '{keep: 1'b1, src: SRC_ARRAY};
    unique case (cls)
      CLS_CMD_SETUP, CLS_BULK_FACTORY_PROGRAM_BUSY: decide = '{keep: 1'b0, src: SRC_STATUS};
      CLS_LOCK_SETUP: begin
        if (c == `CMD_CFG_CONFIRM) begin
          decide = '{keep: 1'b0, src: SRC_ARRAY};
        end else begin
          decide = '{keep: 1'b0, src: SRC_STATUS};
        end
      end
      CLS_READY, CLS_OTP_BUSY: begin
        if (c == `CMD_READ_ARRAY) begin
          decide = '{keep: 1'b0, src: SRC_ARRAY};
        end else if (is_setup(c) || c == `CMD_READ_STATUS) begin
          decide = '{keep: 1'b0, src: SRC_STATUS};
        end else if (c == `CMD_ID_QUERY_A || c == `CMD_ID_QUERY_B) begin
          decide = '{keep: 1'b0, src: SRC_IDQ};
        end else if (!is_legal(c) && match && cls == CLS_READY) begin
          decide = '{keep: 1'b0, src: SRC_ARRAY};
        end
        // D0H, B0H, 50H, 01H, 2FH, 03H and illegal codes without a block match in ready keep the source.
      end
    endcase
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  mux_src_type [PARTS-1:0] mux_sel;
  mux_src_type [PARTS-1:0] next_mux_sel;
  logic [PARTS-1:0]        array_invalid;
  logic [PARTS-1:0]        next_array_invalid;
  logic [`BLK_W-1:0]       blk_latch;
  logic [`BLK_W-1:0]       next_blk_latch;
  logic                    erase_pend;
  logic                    next_erase_pend;
  logic [5:0]              pulses;
  logic [5:0]              next_pulses;
  src_decision_type        dec;
  logic                    in_ready;

  always_comb begin
    next_mux_sel    = mux_sel;
    next_blk_latch  = blk_latch;
    next_erase_pend = erase_pend;
    next_pulses     = 6'h00;
    in_ready        = (chip_class_i == CLS_READY);
    dec             = decide(chip_class_i, wr_req_i.code, wr_req_i.blk == blk_latch);
    if (wr_i) begin
      // Only the addressed partition moves; the others hold their source.
      if (!dec.keep && wr_req_i.part < PARTS[`PART_W:0]) begin
        next_mux_sel[wr_req_i.part] = dec.src;
      end
      if (in_ready && is_setup(wr_req_i.code)) begin
        next_blk_latch = wr_req_i.blk;
      end
      // Confirms are decoded without checking the partition.
      next_erase_pend = in_ready && pgm_suspended_i && wr_req_i.code == `CMD_ERASE;
      if (erase_pend && wr_req_i.code == `CMD_CONFIRM) begin
        next_pulses[4] = 1'b1;
      end else if (chip_class_i == CLS_CMD_SETUP && wr_req_i.code == `CMD_CONFIRM) begin
        next_pulses[3] = 1'b1;
      end
      // One-time-programmable busy is an internal operation too, so clearing is refused there.
      next_pulses[0] = wr_req_i.code == `CMD_CLR_STATUS && !wsm_running_i && in_ready;
      next_pulses[1] = chip_class_i == CLS_BULK_FACTORY_PROGRAM_BUSY && status_bit0_i == 1'b0;
      next_pulses[2] = chip_class_i == CLS_LOCK_SETUP &&
                       (wr_req_i.code == `CMD_LOCK_BLOCK || wr_req_i.code == `CMD_LOCK_DOWN ||
                        wr_req_i.code == `CMD_CFG_CONFIRM || wr_req_i.code == `CMD_CONFIRM);
      next_pulses[5] = in_ready && !is_legal(wr_req_i.code);
    end
    for (int p = 0; p < PARTS; p++) begin
      next_array_invalid[p] = next_mux_sel[p] == SRC_ARRAY && part_busy_i[p];
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Reset points every partition at the array, the power-on read mode.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mux_sel       <= '{default: SRC_ARRAY};
      array_invalid <= '0;
      blk_latch     <= '0;
      erase_pend    <= 1'b0;
      pulses        <= 6'h00;
    end else begin
      mux_sel       <= next_mux_sel;
      array_invalid <= next_array_invalid;
      blk_latch     <= next_blk_latch;
      erase_pend    <= next_erase_pend;
      pulses        <= next_pulses;
    end
  end

  assign mux_sel_o                   = mux_sel;
  assign array_invalid_o             = array_invalid;
  assign first_cycle_block_address_o = blk_latch;
  assign clear_status_o              = pulses[0];
  assign bulk_factory_program_accept_o               = pulses[1];
  assign confirm_ready_o             = pulses[2];
  assign erase_confirm_o             = pulses[3];
  assign second_ignored_o            = pulses[4];
  assign illegal_cmd_o               = pulses[5];

  // ************************************************************
  // Checks
  // ************************************************************
  // Partition 0 is watched, except AST_KEEP and AST_NO_WRITE_HOLD check all; the logic is the same for every index.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  AST_SETUP_STATUS: assert property (wr_i && chip_class_i == CLS_CMD_SETUP && wr_req_i.part == '0
    |=> mux_sel_o[0] == SRC_STATUS) else $error("setup state did not select status");
  AST_CFG_ARRAY: assert property (wr_i && chip_class_i == CLS_LOCK_SETUP && wr_req_i.part == '0
    && wr_req_i.code == `CMD_CFG_CONFIRM |=> mux_sel_o[0] == SRC_ARRAY) else $error("config confirm not array");
  AST_READ_ARRAY: assert property (wr_i && chip_class_i == CLS_READY && wr_req_i.part == '0
    && wr_req_i.code == `CMD_READ_ARRAY |=> mux_sel_o[0] == SRC_ARRAY) else $error("read array not taken");
  AST_KEEP: assert property (wr_i && chip_class_i == CLS_READY && (wr_req_i.code == `CMD_SUSPEND
    || wr_req_i.code == `CMD_CLR_STATUS) |=> $stable(mux_sel_o)) else $error("suspend or clear moved source");
  AST_LOCK_SETUP_STATUS: assert property (wr_i && chip_class_i == CLS_READY && wr_req_i.part == '0
    && wr_req_i.code == `CMD_LOCK_SETUP |=> mux_sel_o[0] == SRC_STATUS) else $error("60H not status");
  AST_IDQ: assert property (wr_i && chip_class_i == CLS_READY && wr_req_i.part == '0
    && wr_req_i.code == `CMD_ID_QUERY_B |=> mux_sel_o[0] == SRC_IDQ) else $error("query not selected");
  AST_NO_WRITE_HOLD: assert property (!wr_i |=> $stable(mux_sel_o))
    else $error("source moved without write");
  AST_IGNORE: assert property (wr_i && in_ready && pgm_suspended_i && wr_req_i.code == `CMD_ERASE ##1
    wr_i && wr_req_i.code == `CMD_CONFIRM |=> second_ignored_o && !erase_confirm_o) else $error("D0H not ignored");
  AST_CLR_BUSY: assert property (wsm_running_i || chip_class_i != CLS_READY
    |=> !clear_status_o) else $error("clear status while running");
  AST_BULK_FACTORY_PROGRAM: assert property (bulk_factory_program_accept_o |-> $past(status_bit0_i) == 1'b0)
    else $error("factory data taken");
  AST_INVALID: assert property (array_invalid_o[0] |-> mux_sel_o[0] == SRC_ARRAY)
    else $error("invalid flag wrong");
  AST_ILLEGAL: assert property (wr_i && in_ready && wr_req_i.code == 8'h77 |=> illegal_cmd_o)
    else $error("illegal missed");

  COV_QUERY: cover property (wr_i && wr_req_i.code == `CMD_ID_QUERY_A ##1 mux_sel_o[0] == SRC_IDQ);
  COV_IGNORE: cover property (second_ignored_o);
  COV_CONFIRM: cover property (confirm_ready_o);
endmodule

// [flash_mux_consts.svh]
// Command codes, widths and field positions for the output source selector.
// Assumes inclusion by the selector package and module only.
`ifndef FLASH_MUX_CONSTS_SVH
`define FLASH_MUX_CONSTS_SVH

`define CMD_W           8
`define PART_W          2
`define BLK_W           10
`define CMD_READ_ARRAY  8'hff
`define CMD_WORD_PGM_A  8'h10
`define CMD_WORD_PGM_B  8'h40
`define CMD_BUF_PGM     8'he8
`define CMD_ERASE       8'h20
`define CMD_BULK_FACTORY_PROGRAM        8'h30
`define CMD_CONFIRM     8'hd0
`define CMD_SUSPEND     8'hb0
`define CMD_READ_STATUS 8'h70
`define CMD_CLR_STATUS  8'h50
`define CMD_ID_QUERY_A  8'h90
`define CMD_ID_QUERY_B  8'h98
`define CMD_LOCK_SETUP  8'h60
`define CMD_OTP_SETUP   8'hc0
`define CMD_LOCK_BLOCK  8'h01
`define CMD_LOCK_DOWN   8'h2f
`define CMD_CFG_CONFIRM 8'h03
`define STATUS_READY_BIT 0

`endif

// [flash_mux_pkg.sv]
// Types shared by the output source selector.
// Assumes the constants header is on the include path.
`include "flash_mux_consts.svh"
package flash_mux_pkg;
  typedef enum logic [2:0] {
    SRC_ARRAY  = 3'b001,
    SRC_IDQ    = 3'b010,
    SRC_STATUS = 3'b100
  } mux_src_type;

  // Chip-wide state groups as reported by the write state machine.
  typedef enum logic [4:0] {
    CLS_READY      = 5'b00001,
    CLS_OTP_BUSY   = 5'b00010,
    CLS_CMD_SETUP  = 5'b00100,
    CLS_LOCK_SETUP = 5'b01000,
    CLS_BULK_FACTORY_PROGRAM_BUSY  = 5'b10000
  } chip_class_type;

  typedef struct packed {
    logic [`CMD_W-1:0]  code;
    logic [`PART_W-1:0] part;
    logic [`BLK_W-1:0]  blk;
  } wr_req_type;

  typedef struct packed {
    logic        keep;
    mux_src_type src;
  } src_decision_type;
endpackage

// [host_cmd_model.sv]
// Host model that issues command bus writes towards the source selector.
// Assumes the bench calls its tasks just after a rising edge of clk_i.
`timescale 1ns/1ps
module host_cmd_model (
  input  wire logic                 clk_i,
  output flash_mux_pkg::wr_req_type wr_req_o,
  output logic                      wr_o
);
  import flash_mux_pkg::*;
  initial begin
    wr_o = 1'b0;
    wr_req_o = '0;
  end
  // One write per edge; the strobe stays up so writes may follow back to back.
  task automatic put(input logic [7:0] c, input logic [1:0] p, input logic [9:0] b);
    wr_o = 1'b1;
    wr_req_o = '{c, p, b};
    @(posedge clk_i);
    #1;
  endtask
  // A released bus shows the inverse of its last value, so stale data never matches.
  task automatic rest();
    wr_o = 1'b0;
    wr_req_o = ~wr_req_o;
    @(posedge clk_i);
    #1;
  endtask
endmodule

// [flash_output_mux_selector_tb_top.sv]
// Self-checking bench for the output source selector.
// Assumes the selector package and the host model are compiled first.
`timescale 1ns/1ps
module flash_output_mux_selector_tb_top;
  import flash_mux_pkg::*;
  localparam int NP = 3;
  logic                  clk, rst_n, run, susp, sb0, wr;
  logic                  clr, bacc, crdy, econf, ign, ill;
  chip_class_type        cls;
  wr_req_type            req;
  logic [NP-1:0]         busy, inv;
  mux_src_type [NP-1:0]  sel;
  logic [9:0]            fa;
  int                    failures, samples_checked;

  host_cmd_model host (.clk_i(clk), .wr_req_o(req), .wr_o(wr));
  // Three partitions leave index 3 free to probe an out-of-range partition.
  flash_output_mux_selector #(.PARTS(NP)) dut (.clk_i(clk), .reset_n_i(rst_n), .wr_i(wr),
    .wr_req_i(req), .chip_class_i(cls), .wsm_running_i(run), .pgm_suspended_i(susp),
    .status_bit0_i(sb0), .part_busy_i(busy), .mux_sel_o(sel), .array_invalid_o(inv),
    .first_cycle_block_address_o(fa), .clear_status_o(clr), .bulk_factory_program_accept_o(bacc),
    .confirm_ready_o(crdy), .erase_confirm_o(econf), .second_ignored_o(ign), .illegal_cmd_o(ill));

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Pulses are packed as clear, accept, confirm, erase, ignored, illegal.
  task automatic step(input logic [7:0] c, input logic [1:0] p, input logic [9:0] b,
                      input mux_src_type e, input logic [5:0] pl);
    host.put(c, p, b);
    check("source", 16'(sel[0]), 16'(e));
    check("pulses", 16'({clr, bacc, crdy, econf, ign, ill}), 16'(pl));
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_ready();
    logic [7:0] su [5] = '{8'h10, 8'h40, 8'he8, 8'h20, 8'h30};
    step(8'h90, 0, 0, SRC_IDQ, 6'h00);
    step(8'hd0, 0, 0, SRC_IDQ, 6'h00);
    step(8'hb0, 0, 0, SRC_IDQ, 6'h00);
    step(8'h50, 0, 0, SRC_IDQ, 6'h20);
    step(8'h70, 0, 0, SRC_STATUS, 6'h00);
    step(8'h01, 0, 0, SRC_STATUS, 6'h00);
    step(8'h2f, 0, 0, SRC_STATUS, 6'h00);
    step(8'h03, 0, 0, SRC_STATUS, 6'h00);
    step(8'hff, 0, 0, SRC_ARRAY, 6'h00);
    step(8'h60, 0, 0, SRC_STATUS, 6'h00);
    step(8'hff, 0, 0, SRC_ARRAY, 6'h00);
    step(8'hc0, 0, 0, SRC_STATUS, 6'h00);
    for (int i = 0; i < 5; i++) begin
      step(8'hff, 0, 5, SRC_ARRAY, 6'h00);
      step(su[i], 0, 5, SRC_STATUS, 6'h00);
    end
    check("latch", 16'(fa), 16'h0005);
    step(8'h77, 0, 6, SRC_STATUS, 6'h01);
    step(8'h77, 0, 5, SRC_ARRAY, 6'h01);
    step(8'h90, 3, 0, SRC_ARRAY, 6'h00);
    step(8'h90, 1, 0, SRC_ARRAY, 6'h00);
    check("part1", 16'(sel[1]), 16'(SRC_IDQ));
    check("part2", 16'(sel[2]), 16'(SRC_ARRAY));
    host.rest();
  endtask
  task automatic s_setup();
    cls = CLS_CMD_SETUP;
    step(8'hff, 0, 0, SRC_STATUS, 6'h00);
    step(8'hd0, 0, 0, SRC_STATUS, 6'h04);
    cls = CLS_LOCK_SETUP;
    step(8'h03, 0, 0, SRC_ARRAY, 6'h08);
    step(8'h01, 0, 0, SRC_STATUS, 6'h08);
    step(8'h03, 0, 0, SRC_ARRAY, 6'h08);
    step(8'h2f, 0, 0, SRC_STATUS, 6'h08);
    cls = CLS_READY;
    susp = 1'b1;
    step(8'h20, 0, 0, SRC_STATUS, 6'h00);
    cls = CLS_CMD_SETUP;
    step(8'hd0, 0, 0, SRC_STATUS, 6'h02);
    susp = 1'b0;
    cls = CLS_READY;
    run = 1'b1;
    step(8'h50, 0, 0, SRC_STATUS, 6'h00);
    run = 1'b0;
    cls = CLS_OTP_BUSY;
    step(8'h50, 0, 0, SRC_STATUS, 6'h00);
    cls = CLS_BULK_FACTORY_PROGRAM_BUSY;
    sb0 = 1'b1;
    step(8'h50, 0, 0, SRC_STATUS, 6'h00);
    sb0 = 1'b0;
    step(8'ha5, 0, 0, SRC_STATUS, 6'h10);
    cls = CLS_READY;
    host.rest();
  endtask
  task automatic s_busy();
    step(8'hff, 0, 0, SRC_ARRAY, 6'h00);
    busy = 3'b001;
    host.rest();
    host.rest();
    check("invalid", 16'(inv), 16'h0001);
    step(8'h70, 0, 0, SRC_STATUS, 6'h00);
    host.rest();
    host.rest();
    check("invalid", 16'(inv), 16'h0000);
    busy = '0;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // The whole run is about fifty cycles; the limit is far beyond it.
  initial begin
    #100us;
    failures++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    cls = CLS_READY;
    run = 1'b0;
    susp = 1'b0;
    sb0 = 1'b0;
    busy = '0;
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    check("reset_sel", 16'(sel), 16'({NP{SRC_ARRAY}}));
    check("reset_rest", 16'({fa, inv, clr, ill}), 16'h0000);
    s_ready();
    s_setup();
    s_busy();
    end_sim();
  end
endmodule
